// [core/sifb_map.svh]
// register offsets, field masks and reset values of the interrupt flag bank
// assumes an 8-bit register port with 7-bit addresses
`ifndef SIFB_MAP_SVH
`define SIFB_MAP_SVH
`define SIFB_OFS_SUMMARY 7'h50
`define SIFB_OFS_FLAGS1 7'h51
`define SIFB_OFS_FLAGS2 7'h52
`define SIFB_OFS_FLAGS3 7'h53
`define SIFB_OFS_MASK1 7'h56
`define SIFB_OFS_MASK2 7'h57
`define SIFB_OFS_MASK3 7'h58
`define SIFB_OFS_FLAGS4 7'h5a
`define SIFB_OFS_MASK4 7'h5e
`define SIFB_USED1 8'hb0
`define SIFB_USED2 8'hf7
`define SIFB_USED3 8'hbc
`define SIFB_USED4 8'hcc
`define SIFB_MUSED2 8'h37
`define SIFB_RST_FLAGS1 8'h00
`define SIFB_RST_FLAGS2 8'h40
`define SIFB_RST_FLAGS3 8'h00
`define SIFB_RST_FLAGS4 8'h00
`define SIFB_RST_MASK1 8'hb0
`define SIFB_RST_MASK2 8'h37
`define SIFB_RST_MASK3 8'hbc
`define SIFB_RST_MASK4 8'hcc
`define SIFB_RST_SUMMARY 8'ha0
`define SIFB_SUM_ALL 7
`define SIFB_SUM_G1 6
`define SIFB_SUM_G2 5
`define SIFB_SUM_G3 4
`define SIFB_SUM_G4 2
`define SIFB_SUM_RESERVED_FIELD 8'h0b
`define SIFB_BIT_FAULT_SLEEP 7
`define SIFB_BIT_POWER_UP 6
`endif

// [core/sifb_pkg.sv]
// types shared by the interrupt flag bank
// assumes the map header carries every number
package sifb_pkg;
  typedef logic [7:0] sifb_byte_t;
  typedef logic [6:0] sifb_addr_t;
endpackage

// [core/sifb_interrupt_flag_bank.sv]
// interrupt flag bank: four sticky write-one-to-clear groups, masks, summary
// assumes event inputs are single-clock pulses or levels from on-chip logic
// and a decoded register port from the serial front end on the same clock
`timescale 1ns/100ps
`include "sifb_map.svh"

module sifb_interrupt_flag_bank (
  input wire logic clock,
  input wire logic srst,
  input wire logic clockEn,
  input wire logic regWrite,
  input wire sifb_pkg::sifb_addr_t regAddr,
  input wire sifb_pkg::sifb_byte_t regWdata,
  output sifb_pkg::sifb_byte_t regRdata,
  input wire logic watchdogErrorEvent,
  input wire logic localWakeEvent,
  input wire logic sleepWaitTimerExpired,
  input wire logic faultSleepEntry,
  input wire logic regulatorOvervoltage,
  input wire logic batteryUndervoltage,
  input wire logic regulatorUndervoltage,
  input wire logic regulatorBusOvertemp,
  input wire logic switchOvertemp,
  input wire logic serialStatusError,
  input wire logic failsafeEntry,
  input wire logic serialChecksumError,
  input wire logic regulatorShort,
  input wire logic restartLimit,
  input wire logic busWake,
  input wire logic busDominantTimeout,
  input wire logic switchOvercurrent,
  input wire logic switchOpenLoad,
  output logic interruptOut,
  output sifb_pkg::sifb_byte_t groupSummary
);
  import sifb_pkg::*;

  localparam sifb_byte_t USED [4] = '{`SIFB_USED1, `SIFB_USED2, `SIFB_USED3, `SIFB_USED4};
  localparam sifb_byte_t MUSED [4] = '{`SIFB_USED1, `SIFB_MUSED2, `SIFB_USED3, `SIFB_USED4};
  localparam sifb_addr_t FOFS [4] =
    '{`SIFB_OFS_FLAGS1, `SIFB_OFS_FLAGS2, `SIFB_OFS_FLAGS3, `SIFB_OFS_FLAGS4};
  localparam sifb_addr_t MOFS [4] =
    '{`SIFB_OFS_MASK1, `SIFB_OFS_MASK2, `SIFB_OFS_MASK3, `SIFB_OFS_MASK4};
  localparam sifb_byte_t FRST [4] =
    '{`SIFB_RST_FLAGS1, `SIFB_RST_FLAGS2, `SIFB_RST_FLAGS3, `SIFB_RST_FLAGS4};
  localparam sifb_byte_t MRST [4] =
    '{`SIFB_RST_MASK1, `SIFB_RST_MASK2, `SIFB_RST_MASK3, `SIFB_RST_MASK4};

  sifb_byte_t flag_r [4];
  sifb_byte_t flag_nxt [4];
  sifb_byte_t mask_r [4];
  sifb_byte_t mask_nxt [4];
  sifb_byte_t evt [4];
  sifb_byte_t sumNow;
  sifb_byte_t rdNow;
  logic irqNow;

  // event vectors laid out at flag bit positions
  always_comb begin
    evt[0] = {watchdogErrorEvent, 1'b0, localWakeEvent, sleepWaitTimerExpired, 4'h0};
    evt[1] = {faultSleepEntry, 1'b0, regulatorOvervoltage, batteryUndervoltage, 1'b0,
              regulatorUndervoltage, regulatorBusOvertemp, switchOvertemp};
    evt[2] = {serialStatusError, 1'b0, failsafeEntry, serialChecksumError, regulatorShort,
              restartLimit, 2'b00};
    evt[3] = {busWake, busDominantTimeout, 2'b00, switchOvercurrent, switchOpenLoad,
              2'b00};
  end

  // fail-safe is an edge-free level here, so entry is taken as a pulse from outside;
  // a held level would re-set the flag and defeat clearing while in fail-safe
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : grp
      always_comb begin
        flag_nxt[g] = flag_r[g];
        mask_nxt[g] = mask_r[g];
        if (regWrite && regAddr == FOFS[g]) begin
          flag_nxt[g] = flag_r[g] & ~regWdata;
        end
        flag_nxt[g] = (flag_nxt[g] | evt[g]) & USED[g];
        if (regWrite && regAddr == MOFS[g]) begin
          mask_nxt[g] = regWdata & MUSED[g];
        end
      end
      always_ff @(posedge clock) begin
        if (srst) begin
          flag_r[g] <= FRST[g];
          mask_r[g] <= MRST[g];
        end else if (clockEn) begin
          flag_r[g] <= flag_nxt[g];
          mask_r[g] <= mask_nxt[g];
        end
      end
    end
  endgenerate

  // summary follows the next flag values so its register matches the flags each cycle
  always_comb begin
    sumNow = 8'h00;
    sumNow[`SIFB_SUM_G1] = |flag_nxt[0];
    sumNow[`SIFB_SUM_G2] = |flag_nxt[1];
    sumNow[`SIFB_SUM_G3] = |flag_nxt[2];
    sumNow[`SIFB_SUM_G4] = |flag_nxt[3];
    sumNow[`SIFB_SUM_ALL] = |{flag_nxt[0], flag_nxt[1], flag_nxt[2], flag_nxt[3]};
    irqNow = |{flag_nxt[0] & mask_nxt[0], flag_nxt[1] & mask_nxt[1],
               flag_nxt[2] & mask_nxt[2], flag_nxt[3] & mask_nxt[3]};
  end

  // read data is registered: it answers one cycle after the address
  always_comb begin
    rdNow = 8'h00;
    for (int i = 0; i < 4; i++) begin
      if (regAddr == FOFS[i]) rdNow = flag_r[i];
      if (regAddr == MOFS[i]) rdNow = mask_r[i];
    end
    if (regAddr == `SIFB_OFS_SUMMARY) rdNow = groupSummary;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      groupSummary <= `SIFB_RST_SUMMARY;
      interruptOut <= 1'b0;
      regRdata <= 8'h00;
    end else if (clockEn) begin
      groupSummary <= sumNow;
      interruptOut <= irqNow;
      regRdata <= rdNow;
    end
  end

  // summary and interrupt registers load from the next flag values, so they match flag_r each cycle; the edge after reset is skipped
  sum_tracks_a: assert property (@(posedge clock) disable iff (srst)
    $past(clockEn) && !$past(srst) |-> groupSummary[`SIFB_SUM_G1] == |flag_r[0])
    else $error("group one summary out of step");
  sum_group2_a: assert property (@(posedge clock) disable iff (srst)
    $past(clockEn) && !$past(srst) |-> groupSummary[`SIFB_SUM_G2] == |flag_r[1])
    else $error("group two summary out of step");
  sum_group3_a: assert property (@(posedge clock) disable iff (srst)
    $past(clockEn) && !$past(srst) |-> groupSummary[`SIFB_SUM_G3] == |flag_r[2])
    else $error("group three summary out of step");
  sum_group4_a: assert property (@(posedge clock) disable iff (srst)
    $past(clockEn) && !$past(srst) |-> groupSummary[`SIFB_SUM_G4] == |flag_r[3])
    else $error("group four summary out of step");
  sum_reserved_field_a: assert property (@(posedge clock) disable iff (srst)
    (groupSummary & `SIFB_SUM_RESERVED_FIELD) == 8'h00)
    else $error("reserved summary bit set");
  sum_global_a: assert property (@(posedge clock) disable iff (srst)
    $past(clockEn) && !$past(srst) |->
    groupSummary[`SIFB_SUM_ALL] == |{flag_r[0], flag_r[1], flag_r[2], flag_r[3]})
    else $error("global summary wrong");
  sum_reset_a: assert property (@(posedge clock)
    srst |=> groupSummary[`SIFB_SUM_ALL])
    else $error("global summary not one after reset");

  wd_set_a: assert property (@(posedge clock) disable iff (srst)
    clockEn && watchdogErrorEvent |=> flag_r[0][7])
    else $error("watchdog flag not set");
  lwu_set_a: assert property (@(posedge clock) disable iff (srst)
    clockEn && localWakeEvent |=> flag_r[0][5])
    else $error("local wake flag not set");
  wake_timeout_error_flag_set_a: assert property (@(posedge clock) disable iff (srst)
    clockEn && sleepWaitTimerExpired |=> flag_r[0][4])
    else $error("wake timeout flag not set");
  hold_flag_a: assert property (@(posedge clock) disable iff (srst)
    clockEn && flag_r[1][`SIFB_BIT_POWER_UP] && !(regWrite && regAddr == `SIFB_OFS_FLAGS2)
    |=> flag_r[1][`SIFB_BIT_POWER_UP])
    else $error("power-up flag dropped");
  pwr_reset_a: assert property (@(posedge clock)
    srst |=> flag_r[1][`SIFB_BIT_POWER_UP])
    else $error("power-up flag not one after reset");
  pwr_clear_a: assert property (@(posedge clock) disable iff (srst)
    clockEn && regWrite && regAddr == `SIFB_OFS_FLAGS2 && regWdata[`SIFB_BIT_POWER_UP]
    |=> !flag_r[1][`SIFB_BIT_POWER_UP])
    else $error("power-up flag not cleared");
  sleep_cause_a: assert property (@(posedge clock) disable iff (srst)
    clockEn && !faultSleepEntry && !flag_r[1][`SIFB_BIT_FAULT_SLEEP]
    |=> !flag_r[1][`SIFB_BIT_FAULT_SLEEP])
    else $error("fault-sleep flag set without cause");
  fault_sleep_a: assert property (@(posedge clock) disable iff (srst)
    clockEn && faultSleepEntry |=> flag_r[1][`SIFB_BIT_FAULT_SLEEP])
    else $error("fault-sleep flag not set");
  ovv_set_a: assert property (@(posedge clock) disable iff (srst)
    clockEn && regulatorOvervoltage |=> flag_r[1][5])
    else $error("overvoltage flag not set");
  batt_uv_a: assert property (@(posedge clock) disable iff (srst)
    clockEn && batteryUndervoltage |=> flag_r[1][4])
    else $error("battery undervoltage flag not set");
  reg_uv_a: assert property (@(posedge clock) disable iff (srst)
    clockEn && regulatorUndervoltage |=> flag_r[1][2])
    else $error("regulator undervoltage flag not set");
  reg_hot_a: assert property (@(posedge clock) disable iff (srst)
    clockEn && regulatorBusOvertemp |=> flag_r[1][1])
    else $error("regulator thermal flag not set");
  switch_hot_a: assert property (@(posedge clock) disable iff (srst)
    clockEn && switchOvertemp |=> flag_r[1][0])
    else $error("switch thermal flag not set");

  serial_err_a: assert property (@(posedge clock) disable iff (srst)
    clockEn && serialStatusError |=> flag_r[2][7])
    else $error("serial error flag not set");
  fs_set_a: assert property (@(posedge clock) disable iff (srst)
    clockEn && failsafeEntry |=> flag_r[2][5])
    else $error("fail-safe flag not set");
  clear_one_a: assert property (@(posedge clock) disable iff (srst)
    clockEn && !failsafeEntry && regWrite && regAddr == `SIFB_OFS_FLAGS3 && regWdata[5]
    |=> !flag_r[2][5])
    else $error("fail-safe flag not cleared");
  checksum_set_a: assert property (@(posedge clock) disable iff (srst)
    clockEn && serialChecksumError |=> flag_r[2][4])
    else $error("checksum flag not set");
  short_set_a: assert property (@(posedge clock) disable iff (srst)
    clockEn && regulatorShort |=> flag_r[2][3])
    else $error("regulator short flag not set");
  restart_set_a: assert property (@(posedge clock) disable iff (srst)
    clockEn && restartLimit |=> flag_r[2][2])
    else $error("restart limit flag not set");
  bus_wake_a: assert property (@(posedge clock) disable iff (srst)
    clockEn && busWake |=> flag_r[3][7])
    else $error("bus wake flag not set");
  dom_timeout_a: assert property (@(posedge clock) disable iff (srst)
    clockEn && busDominantTimeout |=> flag_r[3][6])
    else $error("dominant timeout flag not set");
  overcurrent_a: assert property (@(posedge clock) disable iff (srst)
    clockEn && switchOvercurrent |=> flag_r[3][3])
    else $error("overcurrent flag not set");
  open_load_a: assert property (@(posedge clock) disable iff (srst)
    clockEn && switchOpenLoad |=> flag_r[3][2])
    else $error("open load flag not set");

  mask_write_a: assert property (@(posedge clock) disable iff (srst)
    clockEn && regWrite && regAddr == `SIFB_OFS_MASK1
    |=> mask_r[0] == ($past(regWdata) & MUSED[0]))
    else $error("mask write not taken");
  irq_mask_a: assert property (@(posedge clock) disable iff (srst)
    $past(clockEn) && !$past(srst) |->
    interruptOut == |{flag_r[0] & mask_r[0], flag_r[1] & mask_r[1],
                      flag_r[2] & mask_r[2], flag_r[3] & mask_r[3]})
    else $error("interrupt not matching masked flags");
  mask_reset_a: assert property (@(posedge clock)
    srst |=> mask_r[0] == MRST[0] && mask_r[1] == MRST[1] && mask_r[2] == MRST[2]
    && mask_r[3] == MRST[3])
    else $error("mask reset value wrong");
  reserved_field_low_a: assert property (@(posedge clock) disable iff (srst)
    (mask_r[0] & ~MUSED[0]) == 8'h00 && (mask_r[1] & ~MUSED[1]) == 8'h00
    && (mask_r[2] & ~MUSED[2]) == 8'h00)
    else $error("reserved mask bits set");
  open_load_en_a: assert property (@(posedge clock) disable iff (srst)
    clockEn && regWrite && regAddr == `SIFB_OFS_MASK4
    |=> mask_r[3][2] == $past(regWdata[2]))
    else $error("open-load enable not written");
  reserved_field_zero_a: assert property (@(posedge clock) disable iff (srst)
    (flag_r[2] & ~USED[2]) == 8'h00 && (mask_r[3] & ~MUSED[3]) == 8'h00)
    else $error("reserved bits set");
  reserved_field_flags_a: assert property (@(posedge clock) disable iff (srst)
    (flag_r[0] & ~USED[0]) == 8'h00 && (flag_r[1] & ~USED[1]) == 8'h00
    && (flag_r[3] & ~USED[3]) == 8'h00)
    else $error("reserved flag bits set");
  set_wins_a: assert property (@(posedge clock) disable iff (srst)
    clockEn && busWake && regWrite && regAddr == `SIFB_OFS_FLAGS4 && regWdata[7]
    |=> flag_r[3][7])
    else $error("clear beat a set");
  clear_w1c_a: assert property (@(posedge clock) disable iff (srst)
    clockEn && !watchdogErrorEvent && regWrite && regAddr == `SIFB_OFS_FLAGS1 && regWdata[7]
    |=> !flag_r[0][7])
    else $error("watchdog flag not cleared");
  zero_keeps_a: assert property (@(posedge clock) disable iff (srst)
    clockEn && flag_r[2][4] && !(regWrite && regAddr == `SIFB_OFS_FLAGS3 && regWdata[4])
    |=> flag_r[2][4])
    else $error("flag dropped without a one write");
  rd_flags_a: assert property (@(posedge clock) disable iff (srst)
    clockEn && regAddr == `SIFB_OFS_FLAGS4 |=> regRdata == $past(flag_r[3]))
    else $error("flag read data wrong");
  rd_unmapped_a: assert property (@(posedge clock) disable iff (srst)
    clockEn && regAddr > `SIFB_OFS_MASK4 |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  rd_summary_a: assert property (@(posedge clock) disable iff (srst)
    clockEn && regAddr == `SIFB_OFS_SUMMARY |=> regRdata == $past(groupSummary))
    else $error("summary read data wrong");
  freeze_hold_a: assert property (@(posedge clock) disable iff (srst)
    !clockEn |=> $stable(groupSummary) && $stable(interruptOut) && $stable(regRdata))
    else $error("outputs moved with clock enable low");

  cov_irq_c: cover property (@(posedge clock) disable iff (srst) $rose(interruptOut));
  cov_clear_c: cover property (@(posedge clock) disable iff (srst)
    flag_r[3][3] ##1 !flag_r[3][3]);
  cov_masked_c: cover property (@(posedge clock) disable iff (srst)
    flag_r[0][5] && !mask_r[0][5] && !interruptOut);
  cov_race_c: cover property (@(posedge clock) disable iff (srst)
    clockEn && watchdogErrorEvent && regWrite && regAddr == `SIFB_OFS_FLAGS1 && regWdata[7]);
  cov_freeze_c: cover property (@(posedge clock) disable iff (srst) !clockEn && busWake);
endmodule

// [testbench/sifb_host_model.sv]
// host processor model: byte writes and reads on the decoded register port
// assumes the bank samples the port on the rising edge of clock
`timescale 1ns/100ps
module sifb_host_model (
  input wire logic clock,
  output logic regWrite,
  output sifb_pkg::sifb_addr_t regAddr,
  output sifb_pkg::sifb_byte_t regWdata,
  input wire sifb_pkg::sifb_byte_t regRdata
);
  import sifb_pkg::*;
  initial begin
    regWrite = 1'b0;
    regAddr = 7'h00;
    regWdata = 8'h00;
  end
  // ones clear flags, zeros leave them; data inverted once released
  task automatic wr(input sifb_addr_t a, input sifb_byte_t d);
    @(negedge clock);
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge clock);
    regWrite = 1'b0;
    regWdata = ~d;
  endtask
  task automatic rd(input sifb_addr_t a, output sifb_byte_t d);
    @(negedge clock);
    regAddr = a;
    @(negedge clock);
    d = regRdata;
  endtask
endmodule

// [testbench/sifb_interrupt_flag_bank_test.sv]
// self-checking bench of the interrupt flag bank
// assumes the host model drives the register port; events pulsed here
`timescale 1ns/100ps
module sifb_interrupt_flag_bank_test;
  import sifb_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic clockEn = 1'b1;
  logic [17:0] ev = '0;
  logic regWrite, interruptOut;
  sifb_addr_t regAddr;
  sifb_byte_t regWdata, regRdata, groupSummary, rv;
  int failures = 0;
  int num_checks = 0;
  int bitPos[18] = '{7, 5, 4, 7, 5, 4, 2, 1, 0, 7, 5, 4, 3, 2, 7, 6, 3, 2};
  always #12.5 clock = ~clock;
  sifb_host_model host (.clock(clock), .regWrite(regWrite), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata));
  sifb_interrupt_flag_bank DUT (.clock(clock), .srst(srst), .clockEn(clockEn),
    .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .watchdogErrorEvent(ev[0]), .localWakeEvent(ev[1]), .sleepWaitTimerExpired(ev[2]),
    .faultSleepEntry(ev[3]), .regulatorOvervoltage(ev[4]), .batteryUndervoltage(ev[5]),
    .regulatorUndervoltage(ev[6]), .regulatorBusOvertemp(ev[7]), .switchOvertemp(ev[8]),
    .serialStatusError(ev[9]), .failsafeEntry(ev[10]), .serialChecksumError(ev[11]),
    .regulatorShort(ev[12]), .restartLimit(ev[13]), .busWake(ev[14]),
    .busDominantTimeout(ev[15]), .switchOvercurrent(ev[16]), .switchOpenLoad(ev[17]),
    .interruptOut(interruptOut), .groupSummary(groupSummary));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic reset_values();
    sifb_addr_t a[9] = '{7'h51, 7'h52, 7'h53, 7'h56, 7'h57, 7'h58, 7'h5a, 7'h5e, 7'h60};
    sifb_byte_t e[9] = '{8'h00, 8'h40, 8'h00, 8'hb0, 8'h37, 8'hbc, 8'h00, 8'hcc, 8'h00};
    chk(groupSummary, 8'ha0);
    chk({7'h00, interruptOut}, 8'h00);
    host.rd(7'h50, rv);
    chk(rv, 8'ha0);
    for (int i = 0; i < 9; i++) begin
      host.rd(a[i], rv);
      chk(rv, e[i]);
    end
    host.wr(7'h52, 8'h40);
    host.rd(7'h52, rv);
    chk(rv, 8'h00);
    chk(groupSummary, 8'h00);
    $display("reset values done");
  endtask
  // every event sets its own flag and summary, and all but fault-sleep entry the interrupt, then clears
  task automatic each_event();
    sifb_addr_t a;
    int g;
    for (int i = 0; i < 18; i++) begin
      a = i < 3 ? 7'h51 : i < 9 ? 7'h52 : i < 14 ? 7'h53 : 7'h5a;
      g = i < 3 ? 6 : i < 9 ? 5 : i < 14 ? 4 : 2;
      @(negedge clock) ev[i] = 1'b1;
      @(negedge clock) ev[i] = 1'b0;
      chk(groupSummary, 8'h80 | (8'h01 << g));
      chk({7'h00, interruptOut}, {7'h00, i != 3});
      host.rd(a, rv);
      chk(rv, 8'h01 << bitPos[i]);
      host.wr(a, 8'h00);
      host.rd(a, rv);
      chk(rv, 8'h01 << bitPos[i]);
      host.wr(a, 8'h01 << bitPos[i]);
      host.rd(a, rv);
      chk(rv, 8'h00);
      chk(groupSummary, 8'h00);
    end
    $display("event walk done");
  endtask
  task automatic mask_and_race();
    host.wr(7'h56, 8'h00);
    @(negedge clock) ev[0] = 1'b1;
    host.wr(7'h51, 8'h80);
    ev[0] = 1'b0;
    host.rd(7'h51, rv);
    chk(rv, 8'h80);
    chk({7'h00, interruptOut}, 8'h00);
    chk(groupSummary, 8'hc0);
    host.wr(7'h56, 8'hff);
    host.rd(7'h56, rv);
    chk(rv, 8'hb0);
    chk({7'h00, interruptOut}, 8'h01);
    host.wr(7'h57, 8'hff);
    host.rd(7'h57, rv);
    chk(rv, 8'h37);
    host.wr(7'h5e, 8'h00);
    host.rd(7'h5e, rv);
    chk(rv, 8'h00);
    host.wr(7'h51, 8'hff);
    chk(groupSummary, 8'h00);
    $display("mask and race done");
  endtask
  // events and writes while the clock enable is low are lost
  task automatic freeze_hold();
    @(negedge clock) clockEn = 1'b0;
    ev[14] = 1'b1;
    host.wr(7'h58, 8'h00);
    ev[14] = 1'b0;
    chk(groupSummary, 8'h00);
    @(negedge clock) clockEn = 1'b1;
    host.rd(7'h58, rv);
    chk(rv, 8'hbc);
    host.rd(7'h5a, rv);
    chk(rv, 8'h00);
    $display("freeze done");
  endtask
  // far more than the few hundred cycles the tests need
  initial begin
    #(25 * 20000);
    failures++;
    stop_test();
  end
  initial begin
    repeat (20) @(negedge clock);
    srst = 1'b0;
    reset_values();
    each_event();
    mask_and_race();
    freeze_hold();
    stop_test();
  end
endmodule
